// [hdl/fsw_front_end.v]
// Serial flash command front end: lanes, write enable, status registers
//
// Behaviour
// - Status read repeats until chip select rises
// - Program data wraps within 256-byte page
// - Dual address: odd bits lane one
// - Dual data: odd bit lane one, MSB first
// - Quad address nibbles, mode after address
// - Quad data: upper nibble first
// - Quad read four dummies, word read two
// - Four-lane mode: opcode two clocks, address six except BBh (twelve)
// - 06h sets write enable latch
// - 50h arms one volatile status write
// - 04h clears write enable latch
// - Latch cleared at reset and completions
// - Status registers shift out MSB first
// - Status reads allowed while busy
// - Only writable fields change, lock bits sticky
// - Non-volatile write needs latch set
// - Volatile write keeps locks, reset restores
// - Busy during self-timed write, then latch clears
// - Quad enable frozen in four-lane mode
// - 01h with sixteen bits writes two registers
`timescale 1ns/100ps
`default_nettype none
`include "fsw_regs.vh"
module fsw_front_end #(
   parameter BUSY_CYCLES = `FSW_BUSY_CYCLES
)(
   // Clock and reset
   input wire core_clk_in,
   input wire reset_in,
   // Serial link pins
   input wire cs_n_in,
   input wire sclk_in,
   input wire [3:0] io_in,
   output reg [3:0] io_out,
   output reg [3:0] io_oe_out,
   // Mode and control
   input wire four_lane_command_mode_in,
   input wire restore_in,
   // Array side
   input wire [7:0] array_data_in,
   output reg [23:0] array_addr_out,
   output reg exec_pulse_out,
   output reg [7:0] exec_opcode_out,
   input wire [7:0] page_rd_addr_in,
   output wire [7:0] page_rd_data_out,
   // Status
   output reg busy_out,
   output reg write_enable_latch_out,
   output reg [7:0] status2_out,
   output reg [7:0] status3_out,
   output reg [7:0] status1_hi_out
);
   // ----------------------------------------
   // Phases
   // ----------------------------------------
   localparam P_CMD = 7'h01;
   localparam P_ADDR = 7'h02;
   localparam P_MODE = 7'h04;
   localparam P_DUMMY = 7'h08;
   localparam P_DOUT = 7'h10;
   localparam P_DIN = 7'h20;
   localparam P_SKIP = 7'h40;

   // ----------------------------------------
   // Pin synchronisers and edges
   // ----------------------------------------
   wire [5:0] pins_s;
   reg clk_d_r;
   reg cs_d_r;
   fsw_sync #(.W(6)) u_sync (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .d_in({cs_n_in, sclk_in, io_in}),
      .q_out(pins_s)
   );
   wire cs_s = pins_s[5];
   wire clk_s = pins_s[4];
   wire [3:0] io_s = pins_s[3:0];
   wire rise = clk_s & ~clk_d_r & ~cs_s;
   wire fall = ~clk_s & clk_d_r & ~cs_s;
   wire cs_end = cs_s & ~cs_d_r;

   // ----------------------------------------
   // Frame state
   // ----------------------------------------
   reg [6:0] phase_r;
   reg [2:0] lw_r;
   reg [4:0] cnt_r;
   reg [23:0] sh_r;
   reg [23:0] sh_nxt;
   reg [7:0] op_r;
   reg [2:0] dummy_r;
   reg [7:0] out_sh_r;
   reg [3:0] ocnt_r;
   reg [1:0] nbytes_r;
   reg [7:0] wb0_r;
   reg [7:0] wb1_r;
   reg [7:0] pidx_r;
   reg pgot_r;
   reg varm_r;
   reg [31:0] bcnt_r;
   reg [7:0] v_sr1_r, v_sr2_r, v_sr3_r;
   reg [7:0] nv_sr1_r, nv_sr2_r, nv_sr3_r;
   wire [4:0] cnt_nxt = cnt_r + {2'h0, lw_r};
   wire four_lane_command_mode = four_lane_command_mode_in;
   wire [7:0] sr1_rd = {v_sr1_r[7:2], write_enable_latch_out, busy_out};
   wire pbuf_we = rise & (phase_r == P_DIN) & (cnt_nxt == 5'h08) & (op_r != `FSW_OP_WRSR1)
      & (op_r != `FSW_OP_WRSR2) & (op_r != `FSW_OP_WRSR3);

   fsw_page_buf #(.DEPTH(`FSW_PAGE_BYTES), .AW(8)) u_pbuf (
      .core_clk_in(core_clk_in),
      .wr_en_in(pbuf_we),
      .wr_addr_in(pidx_r),
      .wr_data_in(sh_nxt[7:0]),
      .rd_addr_in(page_rd_addr_in),
      .rd_data_out(page_rd_data_out)
   );

   always @*
   begin
      case (lw_r)
         3'h4: sh_nxt = {sh_r[19:0], io_s};
         3'h2: sh_nxt = {sh_r[21:0], io_s[1:0]};
         default: sh_nxt = {sh_r[22:0], io_s[0]};
      endcase
   end

   // Merge of written byte into a status register
   function [7:0] sr_merge;
      input [7:0] old;
      input [7:0] dat;
      input [7:0] wmask;
      input [7:0] keep1;
      begin
         sr_merge = (old & ~wmask) | (dat & wmask) | (old & keep1);
      end
   endfunction

   // Lanes driven from the top of a byte
   function [3:0] lanes;
      input [7:0] b;
      input [2:0] lw;
      begin
         case (lw)
            3'h4: lanes = b[7:4];
            3'h2: lanes = {2'h0, b[7:6]};
            default: lanes = {2'h0, b[7], 1'h0};
         endcase
      end
   endfunction

   wire is_sw = (op_r == `FSW_OP_WRSR1) | (op_r == `FSW_OP_WRSR2) | (op_r == `FSW_OP_WRSR3);
   wire is_pgm = (op_r == `FSW_OP_PP) | (op_r == `FSW_OP_QPP) | (op_r == `FSW_OP_SECPP);
   wire is_ers = (op_r == `FSW_OP_SE4K) | (op_r == `FSW_OP_BE32K) | (op_r == `FSW_OP_BE64K)
      | (op_r == `FSW_OP_CE1) | (op_r == `FSW_OP_CE2) | (op_r == `FSW_OP_SECER);
   wire sw_len_ok = (cnt_r == 5'h00) & ((nbytes_r == 2'h1) | ((nbytes_r == 2'h2) & (op_r == `FSW_OP_WRSR1)));
   wire [7:0] sr2_wm = four_lane_command_mode ? (`FSW_SR2_WMASK & ~`FSW_SR2_QE_MASK) : `FSW_SR2_WMASK;
   wire [7:0] byte_rd = (op_r == `FSW_OP_RDSR2) ? v_sr2_r :
      (op_r == `FSW_OP_RDSR3) ? v_sr3_r : (op_r == `FSW_OP_RDSR1) ? sr1_rd : array_data_in;

   // ----------------------------------------
   // Frame sequencer
   // ----------------------------------------
   always @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         clk_d_r <= 1'h0;
         cs_d_r <= 1'h1;
         phase_r <= P_CMD;
         lw_r <= 3'h1;
         cnt_r <= 5'h00;
         sh_r <= 24'h000000;
         op_r <= 8'h00;
         dummy_r <= 3'h0;
         out_sh_r <= 8'h00;
         ocnt_r <= 4'h0;
         nbytes_r <= 2'h0;
         wb0_r <= 8'h00;
         wb1_r <= 8'h00;
         pidx_r <= 8'h00;
         pgot_r <= 1'h0;
         io_out <= 4'h0;
         io_oe_out <= 4'h0;
         array_addr_out <= 24'h000000;
      end
      else
      begin
         clk_d_r <= clk_s;
         cs_d_r <= cs_s;
         if (cs_s)
         begin
            phase_r <= P_CMD;
            lw_r <= four_lane_command_mode ? 3'h4 : 3'h1;
            cnt_r <= 5'h00;
            ocnt_r <= 4'h0;
            io_oe_out <= 4'h0;
         end
         else if (rise)
         begin
            sh_r <= sh_nxt;
            case (phase_r)
               P_CMD:
               begin
                  cnt_r <= cnt_nxt;
                  if (cnt_nxt == 5'h08)
                  begin
                     cnt_r <= 5'h00;
                     op_r <= sh_nxt[7:0];
                     nbytes_r <= 2'h0;
                     pgot_r <= 1'h0;
                     case (sh_nxt[7:0])
                        `FSW_OP_RDSR1, `FSW_OP_RDSR2, `FSW_OP_RDSR3:
                           phase_r <= P_DOUT;
                        `FSW_OP_WRSR1, `FSW_OP_WRSR2, `FSW_OP_WRSR3:
                           phase_r <= P_DIN;
                        `FSW_OP_PP, `FSW_OP_QPP, `FSW_OP_SECPP, `FSW_OP_SECER,
                        `FSW_OP_SE4K, `FSW_OP_BE32K, `FSW_OP_BE64K:
                           phase_r <= P_ADDR;
                        `FSW_OP_RD_DIO:
                        begin
                           phase_r <= P_ADDR;
                           lw_r <= 3'h2;
                        end
                        `FSW_OP_RD_QIO, `FSW_OP_RD_WQIO:
                        begin
                           phase_r <= P_ADDR;
                           lw_r <= 3'h4;
                        end
                        default:
                           phase_r <= P_SKIP;
                     endcase
                  end
               end
               P_ADDR:
               begin
                  cnt_r <= cnt_nxt;
                  if (cnt_nxt == `FSW_ADDR_BITS)
                  begin
                     cnt_r <= 5'h00;
                     array_addr_out <= sh_nxt;
                     pidx_r <= sh_nxt[7:0];
                     if (is_pgm)
                     begin
                        phase_r <= P_DIN;
                        lw_r <= (op_r == `FSW_OP_QPP) ? 3'h4 : lw_r;
                     end
                     else if (is_ers)
                        phase_r <= P_SKIP;
                     else
                        phase_r <= P_MODE;
                  end
               end
               P_MODE:
               begin
                  cnt_r <= cnt_nxt;
                  if (cnt_nxt == 5'h08)
                  begin
                     cnt_r <= 5'h00;
                     dummy_r <= (op_r == `FSW_OP_RD_QIO) ? `FSW_QIO_DUMMY :
                        (op_r == `FSW_OP_RD_WQIO) ? `FSW_WQIO_DUMMY : 3'h0;
                     phase_r <= (op_r == `FSW_OP_RD_DIO) ? P_DOUT : P_DUMMY;
                  end
               end
               P_DUMMY:
               begin
                  cnt_r <= cnt_r + 5'h01;
                  if (cnt_r + 5'h01 == {2'h0, dummy_r})
                  begin
                     cnt_r <= 5'h00;
                     phase_r <= P_DOUT;
                  end
               end
               P_DIN:
               begin
                  cnt_r <= cnt_nxt;
                  if (cnt_nxt == 5'h08)
                  begin
                     cnt_r <= 5'h00;
                     if (is_sw)
                     begin
                        if (nbytes_r == 2'h0)
                           wb0_r <= sh_nxt[7:0];
                        else if (nbytes_r == 2'h1)
                           wb1_r <= sh_nxt[7:0];
                        if (nbytes_r != 2'h3)
                           nbytes_r <= nbytes_r + 2'h1;
                     end
                     else
                     begin
                        pidx_r <= pidx_r + 8'h01;
                        pgot_r <= 1'h1;
                     end
                  end
               end
               default:
                  phase_r <= phase_r;
            endcase
         end
         else if (fall && phase_r == P_DOUT)
         begin
            io_oe_out <= (lw_r == 3'h4) ? 4'hF : (lw_r == 3'h2) ? 4'h3 : 4'h2;
            if (ocnt_r == 4'h0)
            begin
               io_out <= lanes(byte_rd, lw_r);
               out_sh_r <= byte_rd << lw_r;
               ocnt_r <= {1'h0, lw_r};
               if (byte_rd == array_data_in && op_r[7])
                  array_addr_out <= array_addr_out + 24'h000001;
            end
            else
            begin
               io_out <= lanes(out_sh_r, lw_r);
               out_sh_r <= out_sh_r << lw_r;
               ocnt_r <= (ocnt_r + {1'h0, lw_r} == 4'h8) ? 4'h0 : ocnt_r + {1'h0, lw_r};
            end
         end
      end
   end

   // ----------------------------------------
   // Write enable, busy and status registers
   // ----------------------------------------
   always @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         write_enable_latch_out <= 1'h0;
         busy_out <= 1'h0;
         bcnt_r <= 32'h00000000;
         varm_r <= 1'h0;
         exec_pulse_out <= 1'h0;
         exec_opcode_out <= 8'h00;
         nv_sr1_r <= `FSW_SR1_RST;
         nv_sr2_r <= `FSW_SR2_RST;
         nv_sr3_r <= `FSW_SR3_RST;
         v_sr1_r <= `FSW_SR1_RST;
         v_sr2_r <= `FSW_SR2_RST;
         v_sr3_r <= `FSW_SR3_RST;
         status1_hi_out <= `FSW_SR1_RST;
         status2_out <= `FSW_SR2_RST;
         status3_out <= `FSW_SR3_RST;
      end
      else
      begin
         exec_pulse_out <= 1'h0;
         if (busy_out)
         begin
            bcnt_r <= bcnt_r - 32'h00000001;
            if (bcnt_r == 32'h00000001)
            begin
               busy_out <= 1'h0;
               write_enable_latch_out <= 1'h0;
            end
         end
         if (restore_in)
         begin
            v_sr1_r <= nv_sr1_r;
            v_sr2_r <= nv_sr2_r;
            v_sr3_r <= nv_sr3_r;
            write_enable_latch_out <= 1'h0;
            varm_r <= 1'h0;
         end
         else if (cs_end && !busy_out && phase_r != P_CMD)
         begin
            varm_r <= 1'h0;
            if (op_r == `FSW_OP_WREN)
               write_enable_latch_out <= 1'h1;
            else if (op_r == `FSW_OP_WRDI)
               write_enable_latch_out <= 1'h0;
            else if (op_r == `FSW_OP_VWREN)
               varm_r <= 1'h1;
            else if (is_sw && sw_len_ok && varm_r)
            begin
               if (op_r == `FSW_OP_WRSR1)
                  v_sr1_r <= sr_merge(v_sr1_r, wb0_r, `FSW_SR1_WMASK, 8'h00);
               if (op_r == `FSW_OP_WRSR2 || nbytes_r == 2'h2)
                  v_sr2_r <= sr_merge(v_sr2_r, (op_r == `FSW_OP_WRSR2) ? wb0_r : wb1_r, sr2_wm,
                     `FSW_SR2_OTP | `FSW_SR2_SRL_MASK);
               if (op_r == `FSW_OP_WRSR3)
                  v_sr3_r <= sr_merge(v_sr3_r, wb0_r, `FSW_SR3_WMASK, 8'h00);
            end
            else if (is_sw && sw_len_ok && write_enable_latch_out)
            begin
               if (op_r == `FSW_OP_WRSR1)
               begin
                  v_sr1_r <= sr_merge(nv_sr1_r, wb0_r, `FSW_SR1_WMASK, 8'h00);
                  nv_sr1_r <= sr_merge(nv_sr1_r, wb0_r, `FSW_SR1_WMASK, 8'h00);
               end
               if (op_r == `FSW_OP_WRSR2 || nbytes_r == 2'h2)
               begin
                  v_sr2_r <= sr_merge(nv_sr2_r, (op_r == `FSW_OP_WRSR2) ? wb0_r : wb1_r, sr2_wm, `FSW_SR2_OTP);
                  nv_sr2_r <= sr_merge(nv_sr2_r, (op_r == `FSW_OP_WRSR2) ? wb0_r : wb1_r, sr2_wm, `FSW_SR2_OTP);
               end
               if (op_r == `FSW_OP_WRSR3)
               begin
                  v_sr3_r <= sr_merge(nv_sr3_r, wb0_r, `FSW_SR3_WMASK, 8'h00);
                  nv_sr3_r <= sr_merge(nv_sr3_r, wb0_r, `FSW_SR3_WMASK, 8'h00);
               end
               busy_out <= 1'h1;
               bcnt_r <= BUSY_CYCLES;
            end
            else if (write_enable_latch_out && ((is_pgm && pgot_r) || (is_ers && cnt_r == 5'h00)))
            begin
               exec_pulse_out <= 1'h1;
               exec_opcode_out <= op_r;
               busy_out <= 1'h1;
               bcnt_r <= BUSY_CYCLES;
            end
         end
         status1_hi_out <= v_sr1_r;
         status2_out <= v_sr2_r;
         status3_out <= v_sr3_r;
      end
   end
endmodule // fsw_front_end
`default_nettype wire

// [hdl/fsw_regs.vh]
// Opcodes, status field layout, masks and timing counts of the flash front end
`ifndef FSW_REGS_VH
`define FSW_REGS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define FSW_OP_WREN 8'h06
`define FSW_OP_VWREN 8'h50
`define FSW_OP_WRDI 8'h04
`define FSW_OP_RDSR1 8'h05
`define FSW_OP_RDSR2 8'h35
`define FSW_OP_RDSR3 8'h15
`define FSW_OP_WRSR1 8'h01
`define FSW_OP_WRSR2 8'h31
`define FSW_OP_WRSR3 8'h11
`define FSW_OP_PP 8'h02
`define FSW_OP_QPP 8'h32
`define FSW_OP_SECPP 8'h42
`define FSW_OP_SECER 8'h44
`define FSW_OP_SE4K 8'h20
`define FSW_OP_BE32K 8'h52
`define FSW_OP_BE64K 8'hD8
`define FSW_OP_CE1 8'hC7
`define FSW_OP_CE2 8'h60
`define FSW_OP_RD_DIO 8'hBB
`define FSW_OP_RD_QIO 8'hEB
`define FSW_OP_RD_WQIO 8'hE7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSW_SR1_BUSY 0
`define FSW_SR1_WEL 1
`define FSW_SR2_SRL 0
`define FSW_SR2_QE 1
// ----------------------------------------
// Writable and one-time masks, reset values
// ----------------------------------------
`define FSW_SR1_WMASK 8'hFC
`define FSW_SR2_WMASK 8'h7B
`define FSW_SR3_WMASK 8'hE0
`define FSW_SR2_OTP 8'h38
`define FSW_SR2_SRL_MASK 8'h01
`define FSW_SR2_QE_MASK 8'h02
`define FSW_SR1_RST 8'h00
`define FSW_SR2_RST 8'h00
`define FSW_SR3_RST 8'h00
// ----------------------------------------
// Lengths and timing
// ----------------------------------------
`define FSW_ADDR_BITS 24
`define FSW_QIO_DUMMY 3'h4
`define FSW_WQIO_DUMMY 3'h2
`define FSW_PAGE_BYTES 256
`define FSW_CLK_MHZ 40
`define FSW_TW_US 100
`define FSW_BUSY_CYCLES (`FSW_TW_US * `FSW_CLK_MHZ)
`endif

// [hdl/fsw_sync.v]
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module fsw_sync #(
   parameter W = 1
)(
   // Clock and reset
   input wire core_clk_in,
   input wire reset_in,
   // Data
   input wire [W-1:0] d_in,
   output reg [W-1:0] q_out
);
   reg [W-1:0] meta_r;
   always @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         meta_r <= {W{1'b0}};
         q_out <= {W{1'b0}};
      end
      else
      begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule // fsw_sync
`default_nettype wire

// [hdl/fsw_page_buf.v]
// Page data buffer with registered read
`timescale 1ns/100ps
`default_nettype none
module fsw_page_buf #(
   parameter DEPTH = 256,
   parameter AW = 8
)(
   // Clock
   input wire core_clk_in,
   // Write port
   input wire wr_en_in,
   input wire [AW-1:0] wr_addr_in,
   input wire [7:0] wr_data_in,
   // Read port
   input wire [AW-1:0] rd_addr_in,
   output reg [7:0] rd_data_out
);
   reg [7:0] mem_r [0:DEPTH-1];
   always @(posedge core_clk_in)
   begin
      if (wr_en_in)
         mem_r[wr_addr_in] <= wr_data_in;
      rd_data_out <= mem_r[rd_addr_in];
   end
endmodule // fsw_page_buf
`default_nettype wire

// [tb/fsw_front_end_checker.sv]
// Concurrent checks on the flash command front end ports
`timescale 1ns/100ps
`default_nettype none
module fsw_front_end_checker #(
   parameter BUSY_CYCLES = 4000
)(
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_in,
   // Link and control
   input wire logic cs_n_in,
   input wire logic four_lane_command_mode_in,
   input wire logic restore_in,
   input wire logic [3:0] io_oe_out,
   // Status
   input wire logic busy_out,
   input wire logic write_enable_latch_out,
   input wire logic [7:0] status2_out,
   input wire logic [7:0] status3_out
);
   int busy_cnt_r;
   int cs_hi_r;
   default clocking cb @(posedge core_clk_in);
   endclocking
   // ----
   // Busy span and idle select counters
   // ----
   always_ff @(posedge core_clk_in)
   begin
      busy_cnt_r <= (busy_out && !reset_in) ? busy_cnt_r + 1 : 0;
      cs_hi_r <= (cs_n_in && !reset_in) ? cs_hi_r + 1 : 0;
   end
   rst_clear_a: assert property (reset_in |=> !busy_out && !write_enable_latch_out && status2_out == 8'h00)
      else $error("reset left status set");
   busy_span_a: assert property (disable iff (reset_in) $fell(busy_out) |-> busy_cnt_r == BUSY_CYCLES)
      else $error("busy span length wrong");
   busy_latch_a: assert property (disable iff (reset_in) $rose(busy_out) |-> cs_n_in && write_enable_latch_out)
      else $error("busy began without latch");
   latch_clear_a: assert property (disable iff (reset_in) $fell(busy_out) |-> !write_enable_latch_out)
      else $error("latch kept after busy");
   fixed_bits_a: assert property (disable iff (reset_in) !status2_out[7] && !status2_out[2] && status3_out[4:0] == 5'h00)
      else $error("read-only status bit changed");
   lock_sticky_a: assert property (disable iff (reset_in) !$past(restore_in) && !$past(restore_in, 2)
      |-> (status2_out & $past(status2_out) & 8'h38) == ($past(status2_out) & 8'h38))
      else $error("lock bit cleared");
   qe_frozen_a: assert property (disable iff (reset_in) four_lane_command_mode_in && $past(four_lane_command_mode_in)
      && $past(four_lane_command_mode_in, 2) && !$past(restore_in) && !$past(restore_in, 2)
      |-> status2_out[1] == $past(status2_out[1]))
      else $error("quad enable changed in four-lane mode");
   oe_idle_a: assert property (disable iff (reset_in) cs_hi_r > 5 |-> io_oe_out == 4'h0)
      else $error("lanes driven while deselected");
   oe_shape_a: assert property (disable iff (reset_in)
      io_oe_out == 4'h0 || io_oe_out == 4'h2 || io_oe_out == 4'h3 || io_oe_out == 4'hF)
      else $error("illegal lane enable pattern");
   latch_restore_a: assert property (disable iff (reset_in) restore_in |=> !write_enable_latch_out)
      else $error("latch kept after restore");
endmodule // fsw_front_end_checker
bind fsw_front_end fsw_front_end_checker #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (.core_clk_in(core_clk_in),
   .reset_in(reset_in), .cs_n_in(cs_n_in), .four_lane_command_mode_in(four_lane_command_mode_in),
   .restore_in(restore_in), .io_oe_out(io_oe_out), .busy_out(busy_out),
   .write_enable_latch_out(write_enable_latch_out), .status2_out(status2_out), .status3_out(status3_out));
`default_nettype wire

// [tb/fsw_host.sv]
// Host controller model for the serial link
`timescale 1ns/100ps
`default_nettype none
module fsw_host (
   // Clock
   input wire logic core_clk_in,
   // Link pins
   output logic cs_n_out,
   output logic sclk_out,
   output logic [3:0] io_out,
   input wire logic [3:0] io_in
);
   initial
   begin
      cs_n_out = 1'h1;
      sclk_out = 1'h0;
      io_out = 4'hA;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   // One link clock, lanes sampled before the rise
   task automatic clk1(input logic [3:0] d, output logic [3:0] q);
      q = io_in;
      io_out = d;
      wt(1);
      sclk_out = 1'h1;
      wt(3);
      sclk_out = 1'h0;
      wt(4);
   endtask
   task automatic begin_frame();
      cs_n_out = 1'h0;
      wt(4);
   endtask
   task automatic end_frame();
      wt(2);
      cs_n_out = 1'h1;
      io_out = ~io_out;
      wt(8);
   endtask
   task automatic send_byte(input logic [7:0] b, input logic quad);
      logic [3:0] q;
      if (quad)
      begin
         clk1(b[7:4], q);
         clk1(b[3:0], q);
      end
      else
         for (int i = 7; i >= 0; i--)
            clk1({3'h5, b[i]}, q);
   endtask
   task automatic recv_byte(input logic quad, output logic [7:0] b);
      logic [3:0] q;
      if (quad)
      begin
         clk1(4'h5, q);
         b[7:4] = q;
         clk1(4'hA, q);
         b[3:0] = q;
      end
      else
         for (int i = 7; i >= 0; i--)
         begin
            clk1({3'h2, i[0]}, q);
            b[i] = q[1];
         end
   endtask
endmodule // fsw_host
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the flash command front end
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
   logic core_clk_in, reset_in, cs_n, sclk, four_lane_command_mode_in, restore_in, qm;
   logic [3:0] h_io, d_io, d_oe;
   logic [7:0] s1h, s2, s3, b1, b2, xop, prd, pra;
   logic busy, write_enable_latch, xp;
   logic [3:0] hq;
   logic [23:0] a_addr;
   int n_exec = 0;
   localparam logic [31:0] DUAL_AM = 32'h1234B600;
   wire logic [3:0] lanes;
   int err_count = 0;
   int n_tests = 0;
   assign lanes = (d_oe & d_io) | (~d_oe & h_io);
   initial
   begin
      core_clk_in = 1'h0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   fsw_front_end #(.BUSY_CYCLES(300)) dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .cs_n_in(cs_n),
      .sclk_in(sclk), .io_in(lanes), .io_out(d_io), .io_oe_out(d_oe),
      .four_lane_command_mode_in(four_lane_command_mode_in), .restore_in(restore_in), .array_data_in(a_addr[7:0]),
      .array_addr_out(a_addr), .exec_pulse_out(xp), .exec_opcode_out(xop), .page_rd_addr_in(pra),
      .page_rd_data_out(prd),
      .busy_out(busy), .write_enable_latch_out(write_enable_latch), .status2_out(s2), .status3_out(s3), .status1_hi_out(s1h));
   fsw_host host (.core_clk_in(core_clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .io_out(h_io), .io_in(lanes));
   always @(posedge core_clk_in)
      if (xp)
         n_exec <= n_exec + 1;
   task automatic complete_run();
      $display("checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] op, input logic [7:0] d, input logic with_data);
      host.begin_frame();
      host.send_byte(op, qm);
      if (with_data)
         host.send_byte(d, qm);
      host.end_frame();
   endtask
   task automatic rd(input logic [7:0] op);
      host.begin_frame();
      host.send_byte(op, qm);
      host.recv_byte(qm, b1);
      host.recv_byte(qm, b2);
      host.end_frame();
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 400 && busy; i++)
         @(negedge core_clk_in);
   endtask
   initial
   begin
      repeat (30000) @(negedge core_clk_in);
      err_count++;
      complete_run();
   end
   initial
   begin
      reset_in = 1'h1;
      restore_in = 1'h0;
      four_lane_command_mode_in = 1'h0;
      qm = 1'h0;
      pra = 8'h00;
      repeat (10) @(negedge core_clk_in);
      reset_in = 1'h0;
      repeat (4) @(negedge core_clk_in);
      `CHK({busy, write_enable_latch, s2, s3}, 18'h00000)
      wr(8'h06, 8'h00, 1'h0);
      `CHK(write_enable_latch, 1'h1)
      wr(8'h04, 8'h00, 1'h0);
      `CHK(write_enable_latch, 1'h0)
      wr(8'h01, 8'hFF, 1'h1);
      `CHK(s1h, 8'h00)
      wr(8'h50, 8'h00, 1'h0);
      `CHK(write_enable_latch, 1'h0)
      wr(8'h31, 8'hFF, 1'h1);
      `CHK({busy, s2}, 9'h07B)
      rd(8'h35);
      `CHK({b1, b2}, 16'h7B7B)
      wr(8'h50, 8'h00, 1'h0);
      wr(8'h31, 8'h00, 1'h1);
      `CHK(s2, 8'h39)
      wr(8'h50, 8'h00, 1'h0);
      wr(8'h11, 8'hFF, 1'h1);
      `CHK(s3, 8'hE0)
      restore_in = 1'h1;
      @(negedge core_clk_in);
      restore_in = 1'h0;
      repeat (2) @(negedge core_clk_in);
      `CHK({s2, s3}, 16'h0000)
      wr(8'h06, 8'h00, 1'h0);
      host.begin_frame();
      host.send_byte(8'h01, qm);
      host.send_byte(8'hFC, qm);
      host.send_byte(8'h42, qm);
      host.end_frame();
      `CHK(busy, 1'h1)
      rd(8'h05);
      `CHK({b1[1:0], b2[1:0]}, 4'hF)
      wait_idle();
      `CHK({busy, write_enable_latch, s1h[7:2], s2}, 16'h3F42)
      wr(8'h06, 8'h00, 1'h0);
      wr(8'h01, 8'h00, 1'h1);
      wait_idle();
      `CHK({s1h[7:2], s2}, 14'h0042)
      wr(8'h06, 8'h00, 1'h0);
      host.begin_frame();
      host.send_byte(8'h42, qm);
      host.send_byte(8'h00, qm);
      host.send_byte(8'h10, qm);
      host.send_byte(8'hFF, qm);
      host.send_byte(8'hA5, qm);
      host.send_byte(8'h5A, qm);
      host.end_frame();
      `CHK({xop, a_addr}, 32'h420010FF)
      wait_idle();
      `CHK({busy, write_enable_latch, n_exec}, 34'h000000001)
      pra = 8'hFF;
      repeat (2) @(negedge core_clk_in);
      `CHK(prd, 8'hA5)
      pra = 8'h00;
      repeat (2) @(negedge core_clk_in);
      `CHK(prd, 8'h5A)
      wr(8'h06, 8'h00, 1'h0);
      host.begin_frame();
      for (int i = 0; i < 4; i++)
         host.send_byte(i ? 8'h00 : 8'h02, qm);
      host.end_frame();
      `CHK({busy, write_enable_latch, n_exec}, 34'h100000001)
      host.begin_frame();
      host.send_byte(8'hBB, qm);
      for (int i = 30; i >= 0; i -= 2)
         host.clk1({2'h0, DUAL_AM[i+1], DUAL_AM[i]}, hq);
      for (int i = 0; i < 4; i++)
      begin
         host.clk1(4'h0, hq);
         b1 = {b1[5:0], hq[1:0]};
      end
      host.end_frame();
      `CHK(b1, 8'hB6)
      four_lane_command_mode_in = 1'h1;
      qm = 1'h1;
      repeat (4) @(negedge core_clk_in);
      wr(8'h50, 8'h00, 1'h0);
      wr(8'h31, 8'h00, 1'h1);
      `CHK(s2, 8'h02)
      rd(8'h35);
      `CHK({b1, b2}, 16'h0202)
      for (int k = 0; k < 2; k++)
      begin
         host.begin_frame();
         host.send_byte(k ? 8'hE7 : 8'hEB, qm);
         host.send_byte(8'h00, qm);
         host.send_byte(8'h10, qm);
         host.send_byte(8'h20, qm);
         host.send_byte(8'h00, qm);
         if (k == 0)
            host.send_byte(8'h00, qm);
         host.send_byte(8'h00, qm);
         host.recv_byte(qm, b1);
         host.end_frame();
         `CHK(b1, 8'h20)
      end
      host.begin_frame();
      for (int i = 0; i < 4; i++)
         host.send_byte((i == 0) ? 8'h77 : (i == 3) ? 8'h70 : 8'h00, qm);
      host.end_frame();
      `CHK({busy, s2}, 9'h002)
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
